// *** logic/fpc_consts.vh ***
// What this block does
// - compare 60H, 264 mode: page in addr[17:9]
// - compare 60H, 256 mode: page in addr[16:8]
// - select rise starts page compare, busy meanwhile
// - compare outcome lands in status bit six
// - bit six: zero match, one any mismatch
// - rewrite 58H, 264 mode: page in addr[17:9]
// - rewrite 58H, 256 mode: page in addr[16:8]
// - rewrite copies page to buffer, programs back
// - rewrite self-timed within max time, busy throughout
// - status read accepted at any time
// - D7H shifts status out msb first next cycle
// - status byte repeats, freshly sampled each time
// - bit seven: one ready, zero busy
// - busy covers all self-timed operations
// - bit one shows sector protection enabled
// - bits five to two hold fixed density code
//
// Purpose: constants of the flash page compare / rewrite / status block
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef FPC_CONSTS_VH
`define FPC_CONSTS_VH

// ************************************************************
// opcodes
// ************************************************************
`define FPC_OP_COMPARE      8'h60
`define FPC_OP_REWRITE      8'h58
`define FPC_OP_STATUS       8'hd7

// ************************************************************
// status byte fields and values
// ************************************************************
`define FPC_ST_READY_BIT    7
`define FPC_ST_COMP_BIT     6
`define FPC_ST_DENS_HI      5
`define FPC_ST_DENS_LO      2
`define FPC_ST_PROT_BIT     1
`define FPC_ST_PSIZE_BIT    0
// density code: value arbitrary, any fixed code will do
`define FPC_DENSITY_CODE    4'h5
`define FPC_COMP_RESET      1'h0

// ************************************************************
// frame and page geometry
// ************************************************************
`define FPC_FRAME_BITS      6'h20
`define FPC_CMD_BITS        6'h08
`define FPC_PAGE_STD        9'h108
`define FPC_PAGE_BIN        9'h100
`define FPC_PAGE_COUNT      512

// ************************************************************
// timing, clock 100 MHz
// ************************************************************
`define FPC_CLK_PERIOD_NS   10
`define FPC_T_REWRITE_US    50
`define FPC_REWRITE_CYC     ((`FPC_T_REWRITE_US * 1000) / `FPC_CLK_PERIOD_NS)

`endif

// *** logic/fpc_flash_seq.v ***
// Purpose: serial flash page compare, auto page rewrite and status read
// Assumes: spi mode 0 or 3; sck, csN and si are asynchronous and oversampled
// Notes:   other self-timed operations report through otherOpBusy
`timescale 1ns/1ns
`include "fpc_consts.vh"
module fpc_flash_seq #(
	parameter REWRITE_CYCLES = `FPC_REWRITE_CYC,
	parameter TW = 20
) (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        sck,
	input  wire        csN,
	input  wire        si,
	output wire        soOut,
	output wire        soOe,
	input  wire        otherOpBusy,
	input  wire        protectEnabled,
	input  wire        pageSize256,
	input  wire        ldMainEn,
	input  wire        ldBufEn,
	input  wire [17:0] ldAddr,
	input  wire [7:0]  ldData,
	output wire        busy
);
	// ************************************************************
	// states
	// ************************************************************
	localparam ST_IDLE = 3'h0;
	localparam ST_CMP  = 3'h1;
	localparam ST_COPY = 3'h2;
	localparam ST_PROG = 3'h3;
	localparam ST_WAIT = 3'h4;

	localparam [31:0]   REWRITE_FULL = REWRITE_CYCLES;
	localparam [TW-1:0] REWRITE_LOAD = REWRITE_FULL[TW-1:0];

	// byte offset of a page in the main array, pages sit on 264-byte strides
	function [17:0] mainAddr;
		input [8:0] page;
		input [8:0] idx;
		begin
			mainAddr = {1'b0, page, 8'h00} + {6'h00, page, 3'h0} + {9'h000, idx};
		end
	endfunction

	// page field: standard mode has one more low don't-care bit
	function [8:0] pageOf;
		input [23:0] addr;
		input        bin;
		begin
			pageOf = bin ? addr[16:8] : addr[17:9];
		end
	endfunction

	// ************************************************************
	// link synchronisers
	// ************************************************************
	reg sckS1_q;
	reg sckS2_q;
	reg sckS3_q;
	reg csS1_q;
	reg csS2_q;
	reg csS3_q;
	reg siS1_q;
	reg siS2_q;

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sckS1_q <= 1'b0;
			sckS2_q <= 1'b0;
			sckS3_q <= 1'b0;
			csS1_q  <= 1'b1;
			csS2_q  <= 1'b1;
			csS3_q  <= 1'b1;
			siS1_q  <= 1'b0;
			siS2_q  <= 1'b0;
		end else begin
			sckS1_q <= sck;
			sckS2_q <= sckS1_q;
			sckS3_q <= sckS2_q;
			csS1_q  <= csN;
			csS2_q  <= csS1_q;
			csS3_q  <= csS2_q;
			siS1_q  <= si;
			siS2_q  <= siS1_q;
		end
	end

	wire sckRise = sckS2_q & ~sckS3_q;
	wire sckFall = ~sckS2_q & sckS3_q;
	wire csRise  = csS2_q & ~csS3_q;
	wire selected = ~csS2_q;

	// ************************************************************
	// state and datapath registers
	// ************************************************************
	reg  [2:0]  state_q;
	reg  [2:0]  state_d;
	reg  [31:0] shReg_q;
	reg  [5:0]  bitCnt_q;
	reg         statRd_q;
	reg  [7:0]  outSh_q;
	reg  [2:0]  outCnt_q;
	reg         so_q;
	reg  [8:0]  page_q;
	reg  [8:0]  idx_q;
	reg  [8:0]  idx_d;
	reg  [8:0]  rdIdx_q;
	reg         rdV_q;
	reg         rdV_d;
	reg         mismatch_q;
	reg         compRes_q;
	reg         psize_q;
	reg         timerStart;
	wire        timerRun;
	wire [7:0]  mainRd;
	wire [7:0]  bufRd;

	wire [8:0] pageLen = psize_q ? `FPC_PAGE_BIN : `FPC_PAGE_STD;
	wire       issueDone = (idx_q == pageLen);
	wire       seqBusy = (state_q != ST_IDLE);

	assign busy = seqBusy | otherOpBusy;

	// status content is rebuilt every cycle so each repeat is fresh
	wire [7:0] statusByte;
	assign statusByte[`FPC_ST_READY_BIT] = ~busy;
	assign statusByte[`FPC_ST_COMP_BIT] = compRes_q;
	assign statusByte[`FPC_ST_DENS_HI:`FPC_ST_DENS_LO] = `FPC_DENSITY_CODE;
	assign statusByte[`FPC_ST_PROT_BIT] = protectEnabled;
	assign statusByte[`FPC_ST_PSIZE_BIT] = psize_q;

	assign soOut = so_q;
	assign soOe = statRd_q & selected;

	wire [7:0] newCmd = {shReg_q[6:0], siS2_q};
	wire       frameOk = (bitCnt_q == `FPC_FRAME_BITS);
	wire [7:0] frameOp = shReg_q[31:24];
	wire [8:0] framePage = pageOf(shReg_q[23:0], psize_q);
	wire       startCmp = csRise & frameOk & ~busy & (frameOp == `FPC_OP_COMPARE);
	wire       startRw = csRise & frameOk & ~busy & (frameOp == `FPC_OP_REWRITE);

	// ************************************************************
	// memories: main array and page buffer
	// ************************************************************
	wire        mainWrSeq = (state_q == ST_PROG) & rdV_q;
	wire        bufWrSeq = (state_q == ST_COPY) & rdV_q;
	wire        mainWr = mainWrSeq | (ldMainEn & ~seqBusy);
	wire        bufWr = bufWrSeq | (ldBufEn & ~seqBusy);
	wire [17:0] mainWrAddr = mainWrSeq ? mainAddr(page_q, rdIdx_q) : ldAddr;
	wire [7:0]  mainWrData = mainWrSeq ? bufRd : ldData;
	wire [8:0]  bufWrAddr = bufWrSeq ? rdIdx_q : ldAddr[8:0];
	wire [7:0]  bufWrData = bufWrSeq ? mainRd : ldData;

	fpc_mem #(
		.DW    (8),
		.AW    (18),
		.DEPTH (`FPC_PAGE_COUNT * 264)
	) mainArr (
		.clk     (clk),
		.sys_rst (sys_rst),
		.wrEn    (mainWr),
		.wrAddr  (mainWrAddr),
		.wrData  (mainWrData),
		.rdAddr  (mainAddr(page_q, idx_q)),
		.rdData  (mainRd)
	);

	fpc_mem #(
		.DW    (8),
		.AW    (9),
		.DEPTH (264)
	) pageBuf (
		.clk     (clk),
		.sys_rst (sys_rst),
		.wrEn    (bufWr),
		.wrAddr  (bufWrAddr),
		.wrData  (bufWrData),
		.rdAddr  (idx_q),
		.rdData  (bufRd)
	);

	fpc_timer #(
		.W (TW)
	) rwTimer (
		.clk     (clk),
		.sys_rst (sys_rst),
		.start   (timerStart),
		.load    (REWRITE_LOAD),
		.running (timerRun)
	);

	// ************************************************************
	// sequencer
	// ************************************************************
	always @* begin
		state_d = state_q;
		idx_d = idx_q;
		rdV_d = 1'b0;
		timerStart = 1'b0;
		case (state_q)
			ST_IDLE: begin
				idx_d = 9'h000;
				if (startCmp) begin
					state_d = ST_CMP;
				end else if (startRw) begin
					state_d = ST_COPY;
					timerStart = 1'b1;
				end
			end
			ST_CMP, ST_COPY, ST_PROG: begin
				if (!issueDone) begin
					rdV_d = 1'b1;
					idx_d = idx_q + 9'h001;
				end else if (!rdV_q) begin
					idx_d = 9'h000;
					if (state_q == ST_CMP) begin
						state_d = ST_IDLE;
					end else if (state_q == ST_COPY) begin
						state_d = ST_PROG;
					end else begin
						state_d = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				if (!timerRun) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q    <= ST_IDLE;
			idx_q      <= 9'h000;
			rdIdx_q    <= 9'h000;
			rdV_q      <= 1'b0;
			page_q     <= 9'h000;
			mismatch_q <= 1'b0;
			compRes_q  <= `FPC_COMP_RESET;
			psize_q    <= 1'b0;
		end else begin
			state_q <= state_d;
			idx_q   <= idx_d;
			rdIdx_q <= idx_q;
			rdV_q   <= rdV_d;
			// page size strap is followed only while idle so a page never changes length mid-run
			if (state_q == ST_IDLE) begin
				psize_q <= pageSize256;
			end
			if (startCmp | startRw) begin
				page_q     <= framePage;
				mismatch_q <= 1'b0;
			end else if ((state_q == ST_CMP) & rdV_q & (mainRd != bufRd)) begin
				mismatch_q <= 1'b1;
			end
			if ((state_q == ST_CMP) & issueDone & ~rdV_q) begin
				compRes_q <= mismatch_q;
			end
		end
	end

	// ************************************************************
	// serial command intake and status output
	// ************************************************************
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			shReg_q  <= 32'h00000000;
			bitCnt_q <= 6'h00;
			statRd_q <= 1'b0;
			outSh_q  <= 8'h00;
			outCnt_q <= 3'h0;
			so_q     <= 1'b0;
		end else if (!selected) begin
			bitCnt_q <= 6'h00;
			statRd_q <= 1'b0;
			outCnt_q <= 3'h0;
		end else begin
			if (sckRise & ~statRd_q) begin
				shReg_q <= {shReg_q[30:0], siS2_q};
				// saturate so an overlong frame never looks like a valid one
				if (bitCnt_q != 6'h3f) begin
					bitCnt_q <= bitCnt_q + 6'h01;
				end
				if ((bitCnt_q == `FPC_CMD_BITS - 6'h01) & (newCmd == `FPC_OP_STATUS)) begin
					statRd_q <= 1'b1;
				end
			end
			if (sckFall & statRd_q) begin
				outCnt_q <= outCnt_q + 3'h1;
				if (outCnt_q == 3'h0) begin
					so_q    <= statusByte[7];
					outSh_q <= {statusByte[6:0], 1'b0};
				end else begin
					so_q    <= outSh_q[7];
					outSh_q <= {outSh_q[6:0], 1'b0};
				end
			end
		end
	end
endmodule

// *** logic/fpc_mem.v ***
// Purpose: simple dual-port byte memory, one write and one registered read
// Assumes: single clock; no reset of contents
// Notes:   read data appears one clock after the address
`timescale 1ns/1ns
module fpc_mem #(
	parameter DW = 8,
	parameter AW = 9,
	parameter DEPTH = 264
) (
	input  wire          clk,
	input  wire          sys_rst,
	input  wire          wrEn,
	input  wire [AW-1:0] wrAddr,
	input  wire [DW-1:0] wrData,
	input  wire [AW-1:0] rdAddr,
	output reg  [DW-1:0] rdData
);
	reg [DW-1:0] mem [0:DEPTH-1];

	always @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdData <= {DW{1'b0}};
		end else begin
			rdData <= mem[rdAddr];
		end
	end
endmodule

// *** logic/fpc_timer.v ***
// Purpose: countdown for self-timed operations
// Assumes: start is a one-cycle pulse
// Notes:   running stays high for exactly load cycles after start
`timescale 1ns/1ns
module fpc_timer #(
	parameter W = 20
) (
	input  wire         clk,
	input  wire         sys_rst,
	input  wire         start,
	input  wire [W-1:0] load,
	output wire         running
);
	reg [W-1:0] count_q;

	assign running = (count_q != {W{1'b0}});

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_q <= {W{1'b0}};
		end else if (start) begin
			count_q <= load;
		end else if (running) begin
			count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule

// *** verif/fpc_flash_seq_bench.sv ***
// Purpose: self-checking bench for the flash page sequencer
// Assumes: rewrite time shortened to 600 cycles
// Notes:   status bytes are checked from a queue by a separate monitor
`timescale 1ns/1ns
`include "fpc_consts.vh"
module fpc_flash_seq_bench;
	reg         clk, sys_rst, otherOpBusy, protectEnabled, pageSize256, ldMainEn, ldBufEn, rdyExp, cmpExp;
	reg  [17:0] ldAddr;
	reg  [7:0]  ldData, rnd, keep;
	reg  [8:0]  page;
	wire        sck, csN, si, soOut, soOe, busy, rdStrobe;
	wire [7:0]  rdByte;
	wire        so = soOe ? soOut : 1'bz;
	reg  [7:0]  expQ[$];
	integer     failures, testsRun, i, m;
	fpc_flash_seq #(.REWRITE_CYCLES(600), .TW(20)) fpc_flash_seq_i (.clk(clk), .sys_rst(sys_rst), .sck(sck),
		.csN(csN), .si(si), .soOut(soOut), .soOe(soOe), .otherOpBusy(otherOpBusy), .protectEnabled(protectEnabled),
		.pageSize256(pageSize256), .ldMainEn(ldMainEn), .ldBufEn(ldBufEn), .ldAddr(ldAddr), .ldData(ldData),
		.busy(busy));
	fpc_host fpc_host_i (.clk(clk), .sck(sck), .csN(csN), .si(si), .so(so), .rdByte(rdByte), .rdStrobe(rdStrobe));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function [7:0] lfsr;
		input [7:0] v;
		lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task chk;
		input [8*6-1:0] name;
		input [7:0] exp;
		input [7:0] got;
		begin
			testsRun = testsRun + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	// the strobe leaves x at time zero, which is not a byte
	always @(rdStrobe) begin
		if ($time > 0) begin
			if (expQ.size() == 0) begin
				testsRun = testsRun + 1;
				failures = failures + 1;
				$display("CHECK FAILED extra expected none seen %h", rdByte);
			end else begin
				chk("status", expQ.pop_front(), rdByte);
			end
		end
	end
	task final_report;
		begin
			$display("comparisons %0d mismatches %0d", testsRun, failures);
			if (failures == 0 && testsRun > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	task status;
		input integer n;
		integer k;
		begin
			// let strap changes made at the calling edge settle before noting them
			@(posedge clk);
			for (k = 0; k < n; k = k + 1)
				expQ.push_back({rdyExp, cmpExp, `FPC_DENSITY_CODE, protectEnabled, pageSize256});
			fpc_host_i.frame({`FPC_OP_STATUS, 24'h0}, 8, 8 * n);
		end
	endtask
	task cmd;
		input [7:0] op;
		input integer nBits;
		begin
			rnd = lfsr(rnd);
			fpc_host_i.frame({op, pageSize256 ? {rnd[6:0], page, rnd} : {rnd[5:0], page, rnd, rnd[0]}}, nBits, 0);
		end
	endtask
	task waitIdle;
		begin
			for (i = 0; i < 2000 && busy !== 1'b0; i = i + 1) @(posedge clk);
			if (busy !== 1'b0) begin
				failures = failures + 1;
				final_report;
			end
		end
	endtask
	task load;
		input integer from;
		input integer upto;
		input main;
		begin
			for (i = from; i < upto; i = i + 1) begin
				rnd = lfsr(rnd);
				if (i == 260 && main) keep = rnd;
				@(posedge clk) ldMainEn <= main;
				ldBufEn <= 1'b0;
				ldAddr <= page * 264 + i;
				ldData <= main ? rnd : ~keep;
				// the buffer takes its byte index from the low address bits
				@(posedge clk) ldMainEn <= 1'b0;
				ldBufEn <= 1'b1;
				ldAddr <= i;
			end
			@(posedge clk) ldMainEn <= 1'b0;
			ldBufEn <= 1'b0;
		end
	endtask
	initial begin
		{otherOpBusy, protectEnabled, pageSize256, ldMainEn, ldBufEn, ldAddr, ldData} = 0;
		{failures, testsRun} = 0;
		{rdyExp, cmpExp, rnd, page} = {2'b10, 8'h4a, 9'h0};
		sys_rst = 1'b1;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk("idle", 8'h00, {7'h0, busy});
		for (m = 0; m < 4; m = m + 1) begin
			@(posedge clk) {pageSize256, protectEnabled} <= m;
			status(2);
		end
		for (m = 0; m < 2; m = m + 1) begin
			@(posedge clk) pageSize256 <= m;
			page = {rnd, rnd[0]};
			load(0, 264, 1'b1);
			cmd(`FPC_OP_COMPARE, 32);
			waitIdle;
			cmpExp = 1'b0;
			status(1);
			load(260, 261, 1'b0);
			cmd(`FPC_OP_COMPARE, 32);
			waitIdle;
			cmpExp = !m;
			status(1);
		end
		for (m = 0; m < 2; m = m + 1) begin
			@(posedge clk) pageSize256 <= m;
			page = m ? {rnd, rnd[0]} : 9'h1ff;
			load(0, 264, 1'b1);
			load(260, 261, 1'b0);
			cmd(`FPC_OP_REWRITE, 32);
			rdyExp = 1'b0;
			status(1);
			waitIdle;
			rdyExp = 1'b1;
			// in 264 mode a skipped copy would have programmed the corrupt byte back into the page
			@(posedge clk) ldBufEn <= 1'b1;
			ldAddr <= 18'h00104;
			ldData <= keep;
			@(posedge clk) ldBufEn <= 1'b0;
			cmd(`FPC_OP_COMPARE, 32);
			waitIdle;
			cmpExp = 1'b0;
			status(1);
		end
		@(posedge clk) pageSize256 <= 1'b0;
		load(260, 261, 1'b0);
		cmd(`FPC_OP_COMPARE, 31);
		repeat (8) @(posedge clk);
		chk("short", 8'h00, {7'h0, busy});
		status(1);
		@(posedge clk) otherOpBusy <= 1'b1;
		rdyExp = 1'b0;
		status(1);
		chk("other", 8'h01, {7'h0, busy});
		@(posedge clk) otherOpBusy <= 1'b0;
		repeat (4) @(posedge clk);
		chk("queue", 8'h00, expQ.size());
		final_report;
	end
endmodule

// *** verif/fpc_flash_seq_sva.sv ***
// Purpose: port assertions for the flash page sequencer
// Assumes: bound into every fpc_flash_seq instance
// Notes:   windows allow for the two-flop input syncers
`timescale 1ns/1ns
module fpc_flash_seq_sva #(
	parameter REWRITE_CYCLES = 600
) (
	input wire clk,
	input wire sys_rst,
	input wire sck,
	input wire csN,
	input wire soOut,
	input wire soOe,
	input wire otherOpBusy,
	input wire busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ****************************************
	// own busy run length
	// ****************************************
	// counts own work only, so a long foreign operation cannot trip the bound
	reg  [15:0] runCnt_q;
	wire [15:0] runCnt_d = (busy && !otherOpBusy) ? runCnt_q + 16'h1 : 16'h0;
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			runCnt_q <= 16'h0;
		else
			runCnt_q <= runCnt_d;
	end
	sequence s_opStart; $rose(busy) && !otherOpBusy; endsequence
	sequence s_selEnd; $rose(csN); endsequence
	sequence s_sckHeld; sck && $past(sck) && $past(sck, 2) && $past(sck, 3); endsequence
	property p_busyOther; otherOpBusy |-> busy; endproperty
	a_busyOther: assert property (p_busyOther) else $error("busy low during other op");
	property p_opAfterSel; s_opStart |-> csN; endproperty
	a_opAfterSel: assert property (p_opAfterSel) else $error("busy rose while selected");
	property p_opMin; s_opStart |=> busy [*8]; endproperty
	a_opMin: assert property (p_opMin) else $error("operation busy too short");
	property p_opMax; runCnt_q <= REWRITE_CYCLES + 536; endproperty
	a_opMax: assert property (p_opMax) else $error("operation busy too long");
	property p_oeRelease; s_selEnd |-> ##[1:4] !soOe; endproperty
	a_oeRelease: assert property (p_oeRelease) else $error("so not released");
	property p_oeHold; (soOe && !csN) |=> soOe; endproperty
	a_oeHold: assert property (p_oeHold) else $error("so dropped while selected");
	property p_oeStart; $rose(soOe) |-> !csN; endproperty
	a_oeStart: assert property (p_oeStart) else $error("so driven unselected");
	property p_soStable; (s_sckHeld and soOe && $past(soOe)) |-> $stable(soOut); endproperty
	a_soStable: assert property (p_soStable) else $error("so changed in high phase");
endmodule
bind fpc_flash_seq fpc_flash_seq_sva #(.REWRITE_CYCLES(REWRITE_CYCLES)) fpc_flash_seq_sva_i (
	.clk(clk), .sys_rst(sys_rst), .sck(sck), .csN(csN), .soOut(soOut), .soOe(soOe),
	.otherOpBusy(otherOpBusy), .busy(busy));

// *** verif/fpc_host.sv ***
// Purpose: host serial master, mode 0, 80 ns clock inside frames only
// Assumes: clk 100 MHz; so sampled late in high phase to cover syncer delay
// Notes:   si toggles outside frames so stale data is never mistaken for valid
`timescale 1ns/1ns
module fpc_host (
	input  wire       clk,
	output reg        sck,
	output reg        csN,
	output reg        si,
	input  wire       so,
	output reg  [7:0] rdByte,
	output reg        rdStrobe
);
	reg     inFrame;
	initial begin
		sck = 1'b0;
		csN = 1'b1;
		si = 1'b0;
		inFrame = 1'b0;
		rdStrobe = 1'b0;
		rdByte = 8'h00;
	end
	always @(posedge clk) if (!inFrame) si <= ~si;
	task frame;
		input [31:0] word;
		input integer nBits;
		input integer nRd;
		integer i;
		begin
			inFrame = 1'b1;
			@(posedge clk) csN <= 1'b0;
			for (i = 0; i < nBits + nRd; i = i + 1) begin
				// data moves with the falling clock edge, which keeps the period at eight clocks
				si <= (i < nBits) ? word[31 - i] : ~si;
				repeat (4) @(posedge clk);
				sck <= 1'b1;
				repeat (3) @(posedge clk);
				@(negedge clk) rdByte = {rdByte[6:0], so};
				if (i >= nBits && (i - nBits) % 8 == 7) rdStrobe = ~rdStrobe;
				@(posedge clk) sck <= 1'b0;
			end
			repeat (4) @(posedge clk);
			csN <= 1'b1;
			repeat (6) @(posedge clk);
			inFrame = 1'b0;
		end
	endtask
endmodule
